// [rtl/ddrc_core.sv]
`timescale 1ns/1ps
`include "ddrc_map.svh"
module ddrc_core
  import ddrc_pkg::*;
#(
  parameter int ROW_W = 13,
  parameter int COL_W = 10,
  parameter int MEM_ROW_BITS = 2
) (
  // Clock and reset.
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Command, address and write data pins.
  input wire ddrc_pins_t pins_i,
  input wire ddrc_wdata_t wdat_i,
  // Read data, two beats per clock.
  output logic [31:0] rd_data_o,
  output logic rd_valid_o,
  output logic rd_half_o,
  // Status.
  output logic [3:0] bank_open_o,
  output logic auto_pre_o,
  output logic refresh_o,
  output logic suspended_o,
  output logic power_down_o,
  output logic dll_enable_o
);
  localparam int MEM_AW = 2 + MEM_ROW_BITS + COL_W;
  localparam int DEPTH = 1 << MEM_AW;

  // Two-flop synchronisers for all pins; logic reads only the second stage.
  ddrc_pins_t pins_m_q, pins_s_q;
  ddrc_wdata_t wdat_m_q, wdat_s_q;
  always_ff @(posedge core_clk_i) begin
    if (rst_i)
    begin
      pins_m_q <= '{cke: 1'b1, cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1,
                    we_n: 1'b1, default: '0};
      pins_s_q <= '{cke: 1'b1, cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1,
                    we_n: 1'b1, default: '0};
      wdat_m_q <= '0;
      wdat_s_q <= '0;
    end
    else
    begin
      pins_m_q <= pins_i;
      pins_s_q <= pins_m_q;
      wdat_m_q <= wdat_i;
      wdat_s_q <= wdat_m_q;
    end
  end

  // Storage: four banks of 16-bit words, a few rows deep in this model.
  logic [15:0] mem [DEPTH];

  // Control state.
  ddrc_state_t state_q, state_d;
  logic [12:0] mr_q, mr_d, emr_q, emr_d;
  logic [3:0] open_q, open_d;
  logic [ROW_W-1:0] row_q [4];
  logic [ROW_W-1:0] row_d [4];
  logic [1:0] bank_q, bank_d;
  logic [COL_W-1:0] col_q, col_d;
  logic ap_q, ap_d;
  logic [1:0] cnt_q, cnt_d;
  logic cke_q, cke_d;
  logic [31:0] st0_q, st0_d, st1_q, st1_d, st2_q, st2_d, rd_q, rd_d;
  logic [2:0] vld_q, vld_d;
  logic rdv_q, rdv_d, apo_q, apo_d, ref_q, ref_d;
  logic frz;
  ddrc_cmd_t cmd;
  logic [1:0] last_cnt;
  logic [2:0] bl_mask;
  logic [MEM_AW-1:0] beat_addr [2];
  logic [1:0] wr_en [2];

  // Command decode from the sampled strobes.
  always_comb
  begin
    cmd = DDRC_NOP;
    if (!pins_s_q.cs_n && !frz)
    begin
      case ({pins_s_q.ras_n, pins_s_q.cas_n, pins_s_q.we_n})
        3'h3: cmd = DDRC_ACT;
        3'h2: cmd = DDRC_PRE;
        3'h5: cmd = DDRC_RD;
        3'h4: cmd = DDRC_WR;
        3'h1: cmd = DDRC_REF;
        3'h0: cmd = DDRC_MRS;
        default: cmd = DDRC_NOP;
      endcase
    end
  end

  // Internal clock stands still from the cycle after clock enable is low.
  assign frz = !cke_q;

  // Burst length decode: pairs per burst less one, and in-block mask.
  always_comb
  begin
    case (mr_q[`DDRC_MR_BL_MSB:`DDRC_MR_BL_LSB])
      `DDRC_BL_4:
      begin
        last_cnt = 2'h1;
        bl_mask = 3'h3;
      end
      `DDRC_BL_8:
      begin
        last_cnt = 2'h3;
        bl_mask = 3'h7;
      end
      default:
      begin
        last_cnt = 2'h0;
        bl_mask = 3'h1;
      end
    endcase
  end

  // Per-beat column and byte write enables for the two data words.
  genvar gk;
  generate
    for (gk = 0; gk < 2; gk++)
    begin : g_beat
      logic [2:0] offs, low;
      logic [COL_W-1:0] col;
      assign offs = {cnt_q, 1'(gk)};
      // Sequential wraps inside the burst block; interleaved uses XOR.
      assign low = mr_q[`DDRC_MR_BT_BIT] ? (col_q[2:0] ^ offs) :
                   3'(col_q[2:0] + offs);
      assign col = {col_q[COL_W-1:3],
                    (col_q[2:0] & ~bl_mask) | (low & bl_mask)};
      assign beat_addr[gk] = {bank_q,
                              row_q[bank_q][MEM_ROW_BITS-1:0], col};
      // Lane mask on the same beat, no delay.
      assign wr_en[gk] = (state_q == DDRC_WRITE && !frz) ?
                         ~wdat_s_q.byte_mask[2*gk +: 2] : 2'h0;
    end
  endgenerate

  // Next-state logic for the command side and burst engine.
  always_comb
  begin
    state_d = state_q;
    mr_d = mr_q;
    emr_d = emr_q;
    open_d = open_q;
    row_d = row_q;
    bank_d = bank_q;
    col_d = col_q;
    ap_d = ap_q;
    cnt_d = cnt_q;
    cke_d = pins_s_q.cke;
    apo_d = 1'b0;
    ref_d = 1'b0;
    if (!frz)
    begin
      // Burst progress and self-timed precharge at its end.
      if (state_q != DDRC_IDLE)
      begin
        cnt_d = cnt_q + 2'h1;
        if (cnt_q == last_cnt)
        begin
          state_d = DDRC_IDLE;
          cnt_d = 2'h0;
          if (ap_q)
          begin
            open_d[bank_q] = 1'b0;
            apo_d = 1'b1;
          end
        end
      end
      case (cmd)
        DDRC_ACT:
        begin
          open_d[pins_s_q.bank_select] = 1'b1;
          row_d[pins_s_q.bank_select] = pins_s_q.addr_in;
        end
        DDRC_PRE:
        begin
          if (!(state_q != DDRC_IDLE && bank_q == pins_s_q.bank_select))
          begin
            open_d[pins_s_q.bank_select] = 1'b0;
          end
        end
        DDRC_RD, DDRC_WR:
        begin
          // New column accesses start only on an idle engine.
          if (state_q == DDRC_IDLE && open_q[pins_s_q.bank_select])
          begin
            state_d = (cmd == DDRC_RD) ? DDRC_READ : DDRC_WRITE;
            bank_d = pins_s_q.bank_select;
            col_d = pins_s_q.addr_in[COL_W-1:0];
            ap_d = pins_s_q.addr_in[`DDRC_AP_BIT];
            cnt_d = 2'h0;
          end
        end
        DDRC_REF:
        begin
          ref_d = (open_q == 4'h0);
        end
        DDRC_MRS:
        begin
          if (open_q == 4'h0 && state_q == DDRC_IDLE)
          begin
            if (pins_s_q.bank_select == `DDRC_BS_MODE)
            begin
              mr_d = pins_s_q.addr_in;
            end
            else if (pins_s_q.bank_select == `DDRC_BS_EXT)
            begin
              emr_d = pins_s_q.addr_in;
            end
          end
        end
        default: ;
      endcase
    end
  end

  // Read pipeline; the latency setting picks the tap.
  always_comb
  begin
    st0_d = st0_q;
    st1_d = st1_q;
    st2_d = st2_q;
    vld_d = vld_q;
    if (!frz)
    begin
      st0_d = {mem[beat_addr[1]], mem[beat_addr[0]]};
      st1_d = st0_q;
      st2_d = st1_q;
      vld_d = {vld_q[1:0], state_q == DDRC_READ};
    end
    if (mr_q[`DDRC_MR_CL_MSB:`DDRC_MR_CL_LSB] == `DDRC_CL_3)
    begin
      rd_d = st2_q;
      rdv_d = vld_q[2] && !frz;
    end
    else
    begin
      rd_d = st1_q;
      rdv_d = vld_q[1] && !frz;
    end
    if (frz)
    begin
      rd_d = rd_q;
    end
  end

  // Registers of all control and read state.
  always_ff @(posedge core_clk_i) begin
    if (rst_i)
    begin
      state_q <= DDRC_IDLE;
      mr_q <= `DDRC_MR_RESET;
      emr_q <= `DDRC_EMR_RESET;
      open_q <= 4'h0;
      for (int b = 0; b < 4; b++)
      begin
        row_q[b] <= '0;
      end
      bank_q <= 2'h0;
      col_q <= '0;
      ap_q <= 1'b0;
      cnt_q <= 2'h0;
      cke_q <= 1'b1;
      st0_q <= '0;
      st1_q <= '0;
      st2_q <= '0;
      rd_q <= '0;
      vld_q <= 3'h0;
      rdv_q <= 1'b0;
      apo_q <= 1'b0;
      ref_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      mr_q <= mr_d;
      emr_q <= emr_d;
      open_q <= open_d;
      row_q <= row_d;
      bank_q <= bank_d;
      col_q <= col_d;
      ap_q <= ap_d;
      cnt_q <= cnt_d;
      cke_q <= cke_d;
      st0_q <= st0_d;
      st1_q <= st1_d;
      st2_q <= st2_d;
      rd_q <= rd_d;
      vld_q <= vld_d;
      rdv_q <= rdv_d;
      apo_q <= apo_d;
      ref_q <= ref_d;
    end
  end

  // Array writes, each byte lane under its own enable, all lanes in the same cycle; masked lanes keep old data.
  always_ff @(posedge core_clk_i) begin
    for (int k = 0; k < 2; k++)
    begin
      for (int l = 0; l < 2; l++)
      begin
        if (wr_en[k][l])
        begin
          mem[beat_addr[k]][8*l +: 8] <= wdat_s_q.data[16*k + 8*l +: 8];
        end
      end
    end
  end

  // Status outputs, all straight from flops.
  // Mode flags are registered from the next-state values, so they keep
  // the same timing as the mode registers themselves.
  logic pd_q;
  logic half_q, dll_q, susp_q;
  always_ff @(posedge core_clk_i) begin
    if (rst_i)
    begin
      pd_q <= 1'b0;
      half_q <= 1'b0;
      dll_q <= 1'b1;
      susp_q <= 1'b0;
    end
    else
    begin
      pd_q <= !pins_s_q.cke && open_d == 4'h0 &&
              state_d == DDRC_IDLE;
      half_q <= (mr_d[`DDRC_MR_CL_MSB:`DDRC_MR_CL_LSB] ==
                 `DDRC_CL_25);
      dll_q <= !emr_d[`DDRC_EMR_DLL_DIS_BIT];
      susp_q <= !cke_d;
    end
  end

  assign rd_data_o = rd_q;
  assign rd_valid_o = rdv_q;
  assign rd_half_o = half_q;
  assign bank_open_o = open_q;
  assign auto_pre_o = apo_q;
  assign refresh_o = ref_q;
  assign suspended_o = susp_q;
  assign power_down_o = pd_q;
  assign dll_enable_o = dll_q;
endmodule : ddrc_core

// [rtl/ddrc_map.svh]
`ifndef DDRC_MAP_SVH
`define DDRC_MAP_SVH
// Mode register fields in the address word.
`define DDRC_MR_BL_LSB 0
`define DDRC_MR_BL_MSB 2
`define DDRC_MR_BT_BIT 3
`define DDRC_MR_CL_LSB 4
`define DDRC_MR_CL_MSB 6
// Extended mode register: delay-locked loop disable bit.
`define DDRC_EMR_DLL_DIS_BIT 0
// Bank select values for the two mode writes.
`define DDRC_BS_MODE 2'h0
`define DDRC_BS_EXT 2'h1
// Address bit that asks for auto precharge.
`define DDRC_AP_BIT 10
// Burst length codes.
`define DDRC_BL_2 3'h1
`define DDRC_BL_4 3'h2
`define DDRC_BL_8 3'h3
// Read latency codes.
`define DDRC_CL_2 3'h2
`define DDRC_CL_25 3'h6
`define DDRC_CL_3 3'h3
// Reset values of the mode registers.
`define DDRC_MR_RESET 13'h0031
`define DDRC_EMR_RESET 13'h0000
`endif

// [rtl/ddrc_pkg.sv]
package ddrc_pkg;
  // Command and address pins as one bundle.
  typedef struct packed {
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [1:0] bank_select;
    logic [12:0] addr_in;
  } ddrc_pins_t;
  // Write data: two 16-bit beats per clock and one mask bit per byte lane.
  typedef struct packed {
    logic [31:0] data;
    logic [3:0] byte_mask;
  } ddrc_wdata_t;
  // Burst engine states in Gray order.
  typedef enum logic [1:0] {
    DDRC_IDLE = 2'h0,
    DDRC_READ = 2'h1,
    DDRC_WRITE = 2'h3
  } ddrc_state_t;
  // Decoded commands.
  typedef enum logic [2:0] {
    DDRC_NOP = 3'h0,
    DDRC_ACT = 3'h1,
    DDRC_PRE = 3'h2,
    DDRC_RD = 3'h3,
    DDRC_WR = 3'h4,
    DDRC_REF = 3'h5,
    DDRC_MRS = 3'h6
  } ddrc_cmd_t;
endpackage : ddrc_pkg

// [verif/ddrc_ctrl_model.sv]
`timescale 1ns/1ps
module ddrc_ctrl_model
  import ddrc_pkg::*;
(
  // Clock.
  input wire logic core_clk_i,
  // Requests from the bench.
  input wire ddrc_cmd_t cmd_i,
  input wire logic [1:0] bank_i,
  input wire logic [12:0] addr_i,
  input wire logic cke_i,
  input wire logic cs_off_i,
  input wire ddrc_wdata_t wd_i,
  input wire logic wd_en_i,
  // Pins toward the device.
  output ddrc_pins_t pins_o,
  output ddrc_wdata_t wdat_o
);
  // Strobe codes indexed by command; unknown codes fall to no-op.
  localparam logic [2:0] RCW [8] = '{3'h7, 3'h3, 3'h2, 3'h5, 3'h4, 3'h1,
    3'h0, 3'h7};
  // Lines start deselected so nothing is decoded before the first command.
  initial
  begin
    pins_o = 20'hf8000;
    wdat_o = 36'h0;
  end
  // Pins move on the falling edge; released lines flip every cycle.
  always @(negedge core_clk_i)
  begin
    pins_o <= {cke_i, cs_off_i, RCW[cmd_i],
      (cmd_i == DDRC_NOP) ? ~pins_o[14:0] : {bank_i, addr_i}};
    wdat_o <= wd_en_i ? wd_i : ~wdat_o;
  end
endmodule : ddrc_ctrl_model

// [verif/ddrc_core_assertions.sv]
`timescale 1ns/1ps
module ddrc_core_assertions
  import ddrc_pkg::*;
(
  // Clock and reset.
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Pins and outputs watched.
  input wire ddrc_pins_t pins_i,
  input wire logic [31:0] rd_data_o,
  input wire logic rd_valid_o,
  input wire logic rd_half_o,
  input wire logic [3:0] bank_open_o,
  input wire logic auto_pre_o,
  input wire logic suspended_o,
  input wire logic power_down_o,
  input wire logic dll_enable_o
);
  ddrc_pins_t p_q [4];
  logic [1:0] ab_q;
  logic half_q;
  logic dll_q;
  logic go;
  logic [2:0] rcw;
  // A command that reached the decoder while running.
  assign go = !p_q[1].cs_n && p_q[1].cke && !suspended_o;
  assign rcw = {p_q[1].ras_n, p_q[1].cas_n, p_q[1].we_n};
  // Pin history and the values the last commands should leave.
  always_ff @(posedge core_clk_i)
  begin
    p_q <= '{pins_i, p_q[0], p_q[1], p_q[2]};
    if (go && rcw == 3'h3)
      ab_q <= p_q[1].bank_select;
    if (go && rcw == 3'h0)
    begin
      half_q <= p_q[1].addr_in[6:4] == 3'h6;
      dll_q <= !p_q[1].addr_in[0];
    end
  end
  default clocking @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);
  cs_ignore_a:
    assert property (pins_i.cs_n && p_q[0].cs_n && p_q[1].cs_n && p_q[2].cs_n
      && p_q[3].cs_n |-> (bank_open_o & ~$past(bank_open_o)) == 4'h0)
    else $error("bank opened while deselected");
  act_open_a:
    assert property (go && rcw == 3'h3 |-> ##5 bank_open_o[ab_q])
    else $error("activate did not open its bank");
  susp_track_a:
    assert property (!p_q[1].cke |-> ##[0:3] suspended_o)
    else $error("clock enable low did not suspend");
  freeze_hold_a:
    assert property (suspended_o && $past(suspended_o) |-> !rd_valid_o
      && $stable(rd_data_o) && $stable(bank_open_o))
    else $error("state moved while suspended");
  pd_idle_a:
    assert property (power_down_o |-> bank_open_o == 4'h0)
    else $error("power-down with a bank open");
  mode_half_a:
    assert property (go && rcw == 3'h0 && p_q[1].bank_select == 2'h0
      && bank_open_o == 4'h0 |-> ##5 rd_half_o == half_q)
    else $error("latency half flag wrong");
  ext_dll_a:
    assert property (go && rcw == 3'h0 && p_q[1].bank_select == 2'h1
      && bank_open_o == 4'h0 |-> ##5 dll_enable_o == dll_q)
    else $error("loop enable wrong");
  ap_close_a:
    assert property (auto_pre_o |-> $past(bank_open_o) != 4'h0)
    else $error("auto precharge with no open bank");
  // Main scenarios reached.
  cover property (rd_valid_o);
  cover property (auto_pre_o);
  cover property (power_down_o);
endmodule : ddrc_core_assertions
bind ddrc_core ddrc_core_assertions ddrc_core_assertions_inst (.*);

// [verif/test_ddrc_core.sv]
`timescale 1ns/1ps
module test_ddrc_core;
  import ddrc_pkg::*;
  logic core_clk_i = 1'h0;
  logic rst_i = 1'h1;
  ddrc_cmd_t cmd = DDRC_NOP;
  logic [1:0] bank = 2'h0;
  logic [12:0] addr = 13'h0;
  logic cke = 1'h1;
  logic cs_off = 1'h0;
  logic wd_en = 1'h0;
  ddrc_wdata_t wd = 36'h0;
  ddrc_pins_t pins_i;
  ddrc_wdata_t wdat_i;
  logic [31:0] rd_data_o;
  logic rd_valid_o, rd_half_o, auto_pre_o, refresh_o, suspended_o;
  logic power_down_o, dll_enable_o;
  logic [3:0] bank_open_o;
  int fail_count = 0;
  int checks = 0;
  int lat;
  int l2;
  int ref_seen = 0;
  int ap_seen = 0;
  // Counts the one-cycle status pulses, looked at mid-cycle.
  always @(negedge core_clk_i)
  begin
    if (refresh_o === 1'h1)
    begin
      ref_seen++;
    end
    if (auto_pre_o === 1'h1)
    begin
      ap_seen++;
    end
  end
  // Controller model and the device.
  ddrc_ctrl_model ddrc_ctrl_model_inst (.core_clk_i(core_clk_i),
    .cmd_i(cmd), .bank_i(bank), .addr_i(addr), .cke_i(cke),
    .cs_off_i(cs_off), .wd_i(wd), .wd_en_i(wd_en), .pins_o(pins_i),
    .wdat_o(wdat_i));
  ddrc_core ddrc_core_inst (.*);
  // Clock of 10 ns.
  initial
  begin
    forever #5 core_clk_i = ~core_clk_i;
  end
  // One counted compare.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  // Waits n falling edges.
  task automatic idle(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask : idle
  // Presents one command for one cycle.
  task automatic issue(input ddrc_cmd_t c, input logic [1:0] b,
    input logic [12:0] a);
    @(posedge core_clk_i);
    cmd = c;
    bank = b;
    addr = a;
    @(posedge core_clk_i);
    cmd = DDRC_NOP;
  endtask : issue
  // Command followed by time for it to settle.
  task automatic op(input ddrc_cmd_t c, input logic [1:0] b,
    input logic [12:0] a);
    issue(c, b, a);
    idle(5);
  endtask : op
  // Write burst of n pairs, one pair a cycle after the command.
  task automatic wr(input logic [1:0] b, input logic [12:0] a, input int n,
    input logic [63:0] d, input logic [3:0] m);
    issue(DDRC_WR, b, a);
    for (int i = 0; i < n; i++)
    begin
      wd = {d[32*i +: 32], m};
      wd_en = 1'h1;
      @(posedge core_clk_i);
    end
    wd_en = 1'h0;
    idle(4);
  endtask : wr
  // Read burst of n pairs; nothing may follow the last pair.
  task automatic rd(input logic [1:0] b, input logic [12:0] a, input int n,
    input logic [63:0] e);
    issue(DDRC_RD, b, a);
    @(negedge core_clk_i);
    for (int i = 0; i < n; i++)
    begin
      lat = 0;
      while (rd_valid_o !== 1'h1 && lat < 20)
      begin
        @(negedge core_clk_i);
        lat++;
      end
      chk(rd_data_o, e[32*i +: 32]);
      @(negedge core_clk_i);
    end
    chk({31'h0, rd_valid_o}, 32'h0);
  endtask : rd
  // Verdict.
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
    begin
      $display("Test passed");
    end
    else
    begin
      $display("Test failed");
    end
    $finish;
  endtask : report_and_stop
  // Hang guard.
  initial
  begin
    #20000;
    fail_count++;
    report_and_stop();
  end
  // Scenarios.
  initial
  begin
    idle(6);
    rst_i = 1'h0;
    chk({27'h0, bank_open_o, dll_enable_o}, 32'h1);
    op(DDRC_MRS, 2'h1, 13'h0001);
    chk({31'h0, dll_enable_o}, 32'h0);
    op(DDRC_MRS, 2'h0, 13'h0061);
    chk({31'h0, rd_half_o}, 32'h1);
    op(DDRC_REF, 2'h0, 13'h0);
    chk(32'(ref_seen), 32'h1);
    op(DDRC_MRS, 2'h0, 13'h0021);
    @(posedge core_clk_i);
    cs_off = 1'h1;
    issue(DDRC_ACT, 2'h0, 13'h0);
    cs_off = 1'h0;
    op(DDRC_ACT, 2'h1, 13'h1abc);
    chk({28'h0, bank_open_o}, 32'h2);
    wr(2'h1, 13'h0004, 1, 64'h1111_2222, 4'h0);
    wr(2'h1, 13'h0004, 1, 64'haaaa_bbbb, 4'h6);
    rd(2'h1, 13'h0004, 1, 64'haa11_22bb);
    l2 = lat;
    op(DDRC_PRE, 2'h1, 13'h0);
    op(DDRC_MRS, 2'h0, 13'h0031);
    op(DDRC_ACT, 2'h1, 13'h1abc);
    rd(2'h1, 13'h0004, 1, 64'haa11_22bb);
    chk(32'(lat - l2), 32'h1);
    op(DDRC_PRE, 2'h1, 13'h0);
    op(DDRC_MRS, 2'h0, 13'h0032);
    op(DDRC_ACT, 2'h2, 13'h0);
    wr(2'h2, 13'h0, 2, 64'h4444_3333_2222_1111, 4'h0);
    rd(2'h2, 13'h0001, 2, 64'h1111_4444_3333_2222);
    op(DDRC_PRE, 2'h2, 13'h0);
    op(DDRC_MRS, 2'h0, 13'h003a);
    op(DDRC_ACT, 2'h2, 13'h0);
    rd(2'h2, 13'h0401, 2, 64'h3333_4444_1111_2222);
    idle(4);
    chk({28'h0, bank_open_o}, 32'h0);
    chk(32'(ap_seen), 32'h1);
    @(posedge core_clk_i);
    cke = 1'h0;
    idle(6);
    chk({30'h0, suspended_o, power_down_o}, 32'h3);
    @(posedge core_clk_i);
    cke = 1'h1;
    op(DDRC_ACT, 2'h3, 13'h0);
    op(DDRC_REF, 2'h0, 13'h0);
    chk(32'(ref_seen), 32'h1);
    @(posedge core_clk_i);
    cke = 1'h0;
    idle(6);
    chk({30'h0, suspended_o, power_down_o}, 32'h2);
    @(posedge core_clk_i);
    cke = 1'h1;
    idle(6);
    chk({26'h0, bank_open_o, suspended_o, power_down_o}, 32'h20);
    report_and_stop();
  end
endmodule : test_ddrc_core
